//--- verilog/gcm_pkg.sv
/*
 * constants for the gpio configuration and interrupt mask block: register
 * offsets, field positions, reset values and debounce timing.
 * assumes a 10 MHz clock and an apb master on the register side.
 */
// Overview of operation
// - masked source: status bit still set on event, interrupt output stays quiet
// - unmasked source: status bit set and interrupt output asserted on event
// - mask bits 7..4: powerdown, comp2 below, comp2 above, watchdog; reset 1
// - mask bits 3..0: pin5 fall, pin5 rise, pin4 fall, pin4 rise; reset 1
// - mask and pin configuration registers reinitialise on the general reset
// - pin zero sleep bit set forces pin low as output during sleep
// - sleep bit acts only when pin has a power-up slot; pin then output
// - sleep bit has no effect in active mode
// - pin zero bit 5 picks push-pull or open-drain; default from boot memory
// - shutdown reset forces open-drain select to 1 when pin is sequenced
// - bit 4 debounce: 91.5 us at 30.5 us rate, or 150 ms at 50 ms rate
// - bit 3 pulldown enable; reset 0 on pin zero, 1 on pin one
// - bit 2 direction, 1 is output; resets 0, pin zero default from boot
// - bit 1 reads pad level, reset value 1
// - bit 0 holds output level, resets 0
// - pin one bit 5 selects register value or first led pulse output
// - status bits set on event, software clears by writing 1
package gcm_pkg;
  localparam logic [11:0] OFF_MASK3 = 12'h055;
  localparam logic [11:0] OFF_PIN0 = 12'h060;
  localparam logic [11:0] OFF_PIN1 = 12'h061;
  localparam logic [11:0] OFF_STS3 = 12'h054;
  localparam logic [7:0] MASK3_RESET = 8'hFF;
  localparam logic [7:0] PIN0_RW_BITS = 8'hBD;
  localparam logic [7:0] PIN1_RW_BITS = 8'h3D;
  localparam logic [7:0] PIN0_RESET = 8'h00;
  localparam logic [7:0] PIN1_RESET = 8'h08;
  localparam int BIT_SLEEP = 7;
  localparam int BIT_ODEN = 5;
  localparam int BIT_SEL = 5;
  localparam int BIT_DEB = 4;
  localparam int BIT_PDEN = 3;
  localparam int BIT_DIR = 2;
  localparam int BIT_LEVEL = 1;
  localparam int BIT_SET = 0;
  localparam int CLK_KHZ = 10000;
  localparam int FAST_RATE_NS = 30500;
  localparam int SLOW_RATE_MS = 50;
  localparam int FAST_DEB_NS = 91500;
  localparam int SLOW_DEB_MS = 150;
  localparam int FAST_TICK_CYC = FAST_RATE_NS * CLK_KHZ / 1000000;
  localparam int SLOW_TICK_CYC = SLOW_RATE_MS * CLK_KHZ;
  // samples needed: filter time over sample period, rounded up for the fast rate, truncated for the slow
  localparam int FAST_SAMPLES = (FAST_DEB_NS + FAST_RATE_NS - 1) / FAST_RATE_NS;
  localparam int SLOW_SAMPLES = SLOW_DEB_MS / SLOW_RATE_MS;
endpackage : gcm_pkg

//--- verilog/gcm_tick_div.sv
/*
 * tick divider: one-cycle enable pulse every PERIOD clocks.
 * assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ns
module gcm_tick_div #(
  parameter int PERIOD = 305
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // tick
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb begin
    if (cnt_q >= 32'(PERIOD - 1)) begin
      cnt_d = 32'h0;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 32'(PERIOD - 1));
endmodule : gcm_tick_div

//--- verilog/gcm_debounce.sv
/*
 * pad debouncer: two-flop synchroniser then a sample filter that accepts
 * a new level after it is seen on a run of consecutive sample ticks.
 * assumes tick enables from dividers on the same clock.
 */
`timescale 1ns/1ns
module gcm_debounce (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // timing
  input wire logic slowSel,
  input wire logic fastTick,
  input wire logic slowTick,
  // pad
  input wire logic padIn,
  output logic level
);
  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic level_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic tick;
  logic [3:0] need;

  assign tick = slowSel ? slowTick : fastTick;
  assign need = slowSel ? 4'(gcm_pkg::SLOW_SAMPLES) : 4'(gcm_pkg::FAST_SAMPLES);

  always_comb begin
    level_d = level_q;
    run_d = run_q;
    if (tick) begin
      if (sync2_q == level_q) begin
        run_d = 4'h0;
      end else if (run_q + 4'h1 >= need) begin
        level_d = sync2_q;
        run_d = 4'h0;
      end else begin
        run_d = run_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      level_q <= 1'b1;
      run_q <= 4'h0;
    end else begin
      sync1_q <= padIn;
      sync2_q <= sync1_q;
      level_q <= level_d;
      run_q <= run_d;
    end
  end

  assign level = level_q;
endmodule : gcm_debounce

//--- verilog/gcm_top.sv
/*
 * gpio pin zero/one configuration and third interrupt mask register with
 * its status register, behind an apb slave.
 * assumes event pulses on clk; pad inputs asynchronous; boot defaults stable
 * while reset is low and caught on the first clock after its release.
 */
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module gcm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources, one-cycle pulses, bit order as mask register
  input wire logic [7:0] srcEvent,
  output logic irqOut,
  // power state and sequencing
  input wire logic sleepMode,
  input wire logic pin0InSequence,
  input wire logic shutdownReset,
  input wire logic bootOpenDrain,
  input wire logic bootPin0Out,
  input wire logic ledPulseOne,
  // pin zero pad
  input wire logic pin0PadIn,
  output logic pin0PadOut,
  output logic pin0PadOe,
  output logic pin0Pulldown,
  // pin one pad
  input wire logic pin1PadIn,
  output logic pin1PadOut,
  output logic pin1PadOe,
  output logic pin1Pulldown
);
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] sts_q;
  logic [7:0] sts_d;
  logic [7:0] pin0_q;
  logic [7:0] pin0_d;
  logic [7:0] pin1_q;
  logic [7:0] pin1_d;
  logic bootDone_q;
  logic bootDone_d;
  logic fastTick;
  logic slowTick;
  logic lvl0;
  logic lvl1;
  logic wrEn;
  logic [7:0] wb;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic known;
  logic sleepForce;
  logic pin0Drive;
  logic pin1Val;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == {off[9:0], 2'b00});
  endfunction : hit

  gcm_tick_div #(.PERIOD(gcm_pkg::FAST_TICK_CYC)) uFast (
    .clk(clk),
    .rstn(rstn),
    .tick(fastTick)
  );

  gcm_tick_div #(.PERIOD(gcm_pkg::SLOW_TICK_CYC)) uSlow (
    .clk(clk),
    .rstn(rstn),
    .tick(slowTick)
  );

  gcm_debounce uDeb0 (
    .clk(clk),
    .rstn(rstn),
    .slowSel(pin0_q[gcm_pkg::BIT_DEB]),
    .fastTick(fastTick),
    .slowTick(slowTick),
    .padIn(pin0PadIn),
    .level(lvl0)
  );

  gcm_debounce uDeb1 (
    .clk(clk),
    .rstn(rstn),
    .slowSel(pin1_q[gcm_pkg::BIT_DEB]),
    .fastTick(fastTick),
    .slowTick(slowTick),
    .padIn(pin1PadIn),
    .level(lvl1)
  );

  // zero-wait apb slave
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite && pstrb[0];
  assign wb = pwdata[7:0];
  assign known = hit(paddr, gcm_pkg::OFF_MASK3) || hit(paddr, gcm_pkg::OFF_STS3)
    || hit(paddr, gcm_pkg::OFF_PIN0) || hit(paddr, gcm_pkg::OFF_PIN1);
  assign pslverr = psel && penable && !known;

  always_comb begin
    mask_d = mask_q;
    pin0_d = pin0_q;
    pin1_d = pin1_q;
    bootDone_d = 1'b1;
    // event set wins over write-one clear
    sts_d = sts_q;
    if (wrEn && hit(paddr, gcm_pkg::OFF_STS3)) begin
      sts_d = sts_q & ~wb;
    end
    sts_d = sts_d | srcEvent;
    if (wrEn && hit(paddr, gcm_pkg::OFF_MASK3)) begin
      mask_d = wb;
    end
    if (wrEn && hit(paddr, gcm_pkg::OFF_PIN0)) begin
      pin0_d = wb & gcm_pkg::PIN0_RW_BITS;
    end
    if (wrEn && hit(paddr, gcm_pkg::OFF_PIN1)) begin
      pin1_d = wb & gcm_pkg::PIN1_RW_BITS;
    end
    if (!bootDone_q) begin
      pin0_d[gcm_pkg::BIT_ODEN] = bootOpenDrain;
      pin0_d[gcm_pkg::BIT_DIR] = bootPin0Out;
    end
    if (shutdownReset && pin0InSequence) begin
      pin0_d[gcm_pkg::BIT_ODEN] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= gcm_pkg::MASK3_RESET;
      sts_q <= 8'h00;
      pin0_q <= gcm_pkg::PIN0_RESET;
      pin1_q <= gcm_pkg::PIN1_RESET;
      bootDone_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      sts_q <= sts_d;
      pin0_q <= pin0_d;
      pin1_q <= pin1_d;
      bootDone_q <= bootDone_d;
    end
  end

  // read path
  always_comb begin
    rdata_d = 32'h0;
    if (hit(paddr, gcm_pkg::OFF_MASK3)) begin
      rdata_d[7:0] = mask_q;
    end else if (hit(paddr, gcm_pkg::OFF_STS3)) begin
      rdata_d[7:0] = sts_q;
    end else if (hit(paddr, gcm_pkg::OFF_PIN0)) begin
      rdata_d[7:0] = pin0_q | {6'h00, lvl0, 1'b0};
    end else if (hit(paddr, gcm_pkg::OFF_PIN1)) begin
      rdata_d[7:0] = pin1_q | {6'h00, lvl1, 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  assign irqOut = |(sts_q & ~mask_q);

  // pin zero drive
  assign sleepForce = sleepMode && pin0InSequence && pin0_q[gcm_pkg::BIT_SLEEP];
  assign pin0Drive = sleepForce ? 1'b0 : pin0_q[gcm_pkg::BIT_SET];
  always_comb begin
    if (sleepForce || pin0_q[gcm_pkg::BIT_DIR]) begin
      if (pin0_q[gcm_pkg::BIT_ODEN] && pin0Drive) begin
        pin0PadOe = 1'b0;
      end else begin
        pin0PadOe = 1'b1;
      end
    end else begin
      pin0PadOe = 1'b0;
    end
  end
  assign pin0PadOut = pin0Drive;
  assign pin0Pulldown = pin0_q[gcm_pkg::BIT_PDEN];

  // pin one drive
  assign pin1Val = pin1_q[gcm_pkg::BIT_SEL] ? ledPulseOne : pin1_q[gcm_pkg::BIT_SET];
  assign pin1PadOut = pin1Val;
  assign pin1PadOe = pin1_q[gcm_pkg::BIT_DIR];
  assign pin1Pulldown = pin1_q[gcm_pkg::BIT_PDEN];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_masked_quiet: assert property (
    (srcEvent == 8'h01 && mask_q == 8'hFF && sts_q == 8'h00 && !wrEn)
      |=> (sts_q[0] && !irqOut))
    else $error("masked event raised interrupt or lost status");
  a_unmasked_irq: assert property (
    (srcEvent[4] && !mask_q[4] && !wrEn) |=> irqOut)
    else $error("unmasked event did not raise interrupt");
  a_set_beats_clr: assert property (
    (srcEvent[7] && wrEn && hit(paddr, gcm_pkg::OFF_STS3)) |=> sts_q[7])
    else $error("status event lost under clear");
  a_clear_one: assert property (
    (wrEn && hit(paddr, gcm_pkg::OFF_STS3) && wb[5] && !srcEvent[5]) |=> !sts_q[5])
    else $error("write one did not clear status");
  a_mask_reset: assert property (
    $rose(rstn) |-> mask_q == gcm_pkg::MASK3_RESET)
    else $error("mask not reset to all ones");
  a_sleep_low: assert property (
    (sleepForce && !(shutdownReset)) |-> (pin0PadOe && !pin0PadOut))
    else $error("sleep force did not drive pin low");
  a_active_nosleep: assert property (
    (!sleepMode && !pin0_q[gcm_pkg::BIT_DIR]) |-> !pin0PadOe)
    else $error("input pin driven in active mode");
  a_shutdown_od: assert property (
    (shutdownReset && pin0InSequence && bootDone_q) |=> pin0_q[gcm_pkg::BIT_ODEN])
    else $error("shutdown reset did not force open drain");
  a_led_select: assert property (
    pin1_q[gcm_pkg::BIT_SEL] |-> pin1PadOut == ledPulseOne)
    else $error("led output not routed to pin one");
  a_reserved_zero: assert property (
    (pin1_q[7:6] == 2'b00) && (pin0_q[6] == 1'b0))
    else $error("reserved bit holds a one");

  c_irq: cover property (irqOut);
  c_sleep: cover property (sleepForce);
  c_led: cover property (pin1_q[gcm_pkg::BIT_SEL] && pin1PadOe);
endmodule : gcm_top

//--- dv/gcm_pad_load.sv
/*
 * pad load model for one pin: weak external pull-up, the pin's own
 * pulldown and the device driver. assumes oe high while the device drives.
 */
`timescale 1ns/1ns
module gcm_pad_load (
  // device side
  input wire logic padOut,
  input wire logic padOe,
  input wire logic pullDownEn,
  // pad
  output logic padLevel
);
  // driver wins, else pulldown against the weak pull-up
  assign padLevel = padOe ? padOut : ~pullDownEn;
endmodule : gcm_pad_load

//--- dv/tb.sv
/*
 * self-checking bench for the gpio config and interrupt mask block.
 * assumes the apb slave, pad load models and a 10 MHz clock.
 */
`timescale 1ns/1ns
module tb;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irqOut;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [7:0] srcEvent;
  logic sleepMode, pin0InSequence, shutdownReset, bootOpenDrain, bootPin0Out;
  logic ledPulseOne, p0In, p0Out, p0Oe, p0Pd, p1In, p1Out, p1Oe, p1Pd, se;
  int errTotal, totalChecks;
  gcm_top gcm_top_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srcEvent(srcEvent), .irqOut(irqOut),
    .sleepMode(sleepMode), .pin0InSequence(pin0InSequence),
    .shutdownReset(shutdownReset), .bootOpenDrain(bootOpenDrain),
    .bootPin0Out(bootPin0Out), .ledPulseOne(ledPulseOne), .pin0PadIn(p0In),
    .pin0PadOut(p0Out), .pin0PadOe(p0Oe), .pin0Pulldown(p0Pd), .pin1PadIn(p1In),
    .pin1PadOut(p1Out), .pin1PadOe(p1Oe), .pin1Pulldown(p1Pd));
  gcm_pad_load gcm_pad_load_inst (.padOut(p0Out), .padOe(p0Oe), .pullDownEn(p0Pd),
    .padLevel(p0In));
  gcm_pad_load gcm_pad_load_one (.padOut(p1Out), .padOe(p1Oe), .pullDownEn(p1Pd),
    .padLevel(p1In));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [11:0] ba(input logic [11:0] o);
    return o << 2;
  endfunction : ba
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      errTotal++;
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("read %h", a), {24'h000000, e}, r);
  endtask : rd
  task pins(input logic o, input logic e);
    repeat (2) @(posedge clk);
    chk("pin0 out/oe", {30'h0, o, e}, {30'h0, p0Out, p0Oe});
  endtask : pins
  task giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
  initial begin
    {rstn, psel, penable, pwrite, sleepMode, pin0InSequence} = 6'h00;
    {shutdownReset, bootPin0Out, ledPulseOne} = 3'h0;
    bootOpenDrain = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    srcEvent = 8'h00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ba(gcm_pkg::OFF_MASK3), 8'hFF);
    rd(ba(gcm_pkg::OFF_PIN0), 8'h22);
    rd(ba(gcm_pkg::OFF_PIN1), 8'h0A);
    chk("pulldowns", 32'h1, {30'h0, p0Pd, p1Pd});
    $display("test reset values done");
    wr(ba(gcm_pkg::OFF_PIN0), 8'hFF);
    rd(ba(gcm_pkg::OFF_PIN0), 8'hBF);
    wr(ba(gcm_pkg::OFF_PIN1), 8'hFF);
    rd(ba(gcm_pkg::OFF_PIN1), 8'h3F);
    ledPulseOne <= 1'b1;
    repeat (2) @(posedge clk);
    chk("pin1 out", 32'h1, {31'h0, p1Out});
    ledPulseOne <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin1 out", 32'h0, {31'h0, p1Out});
    wr(ba(gcm_pkg::OFF_PIN1), 8'h05);
    repeat (2) @(posedge clk);
    chk("pin1 out", 32'h1, {31'h0, p1Out});
    chk("pin1 oe", 32'h1, {31'h0, p1Oe});
    xfer(1'b0, 12'h3F0, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, se});
    chk("unmapped data", 32'h0, r);
    pstrb <= 4'hE;
    wr(ba(gcm_pkg::OFF_MASK3), 8'h00);
    pstrb <= 4'hF;
    rd(ba(gcm_pkg::OFF_MASK3), 8'hFF);
    $display("test fields done");
    for (int i = 0; i < 8; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(ba(gcm_pkg::OFF_MASK3), (m == 1) ? 8'(~(8'h01 << i)) : 8'hFF);
        srcEvent <= 8'(8'h01 << i);
        @(posedge clk);
        srcEvent <= 8'h00;
        repeat (2) @(posedge clk);
        chk("irqOut", m, {31'h0, irqOut});
        rd(ba(gcm_pkg::OFF_STS3), 8'(8'h01 << i));
        wr(ba(gcm_pkg::OFF_STS3), 8'(8'h01 << i));
        rd(ba(gcm_pkg::OFF_STS3), 8'h00);
        chk("irqOut", 32'h0, {31'h0, irqOut});
      end
    end
    // event pulse lands on the same edge as the clear write
    fork
      wr(ba(gcm_pkg::OFF_STS3), 8'h80);
      begin
        @(posedge clk);
        srcEvent <= 8'h80;
        @(posedge clk);
        srcEvent <= 8'h00;
      end
    join
    rd(ba(gcm_pkg::OFF_STS3), 8'h80);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    wr(ba(gcm_pkg::OFF_STS3), 8'h80);
    rd(ba(gcm_pkg::OFF_STS3), 8'h00);
    $display("test interrupts done");
    wr(ba(gcm_pkg::OFF_PIN0), 8'h81);
    pins(1'b1, 1'b0);
    sleepMode <= 1'b1;
    pins(1'b1, 1'b0);
    pin0InSequence <= 1'b1;
    pins(1'b0, 1'b1);
    wr(ba(gcm_pkg::OFF_PIN0), 8'h05);
    pins(1'b1, 1'b1);
    sleepMode <= 1'b0;
    wr(ba(gcm_pkg::OFF_PIN0), 8'h25);
    pins(1'b1, 1'b0);
    wr(ba(gcm_pkg::OFF_PIN0), 8'h24);
    pins(1'b0, 1'b1);
    wr(ba(gcm_pkg::OFF_PIN0), 8'h05);
    shutdownReset <= 1'b1;
    @(posedge clk);
    shutdownReset <= 1'b0;
    rd(ba(gcm_pkg::OFF_PIN0), 8'h27);
    $display("test pin drive done");
    wr(ba(gcm_pkg::OFF_PIN0), 8'h08);
    repeat (500) @(posedge clk);
    rd(ba(gcm_pkg::OFF_PIN0), 8'h0A);
    repeat (800) @(posedge clk);
    rd(ba(gcm_pkg::OFF_PIN0), 8'h08);
    // slow filter must still hold the old level long after a fast one would move
    wr(ba(gcm_pkg::OFF_PIN0), 8'h10);
    repeat (1300) @(posedge clk);
    rd(ba(gcm_pkg::OFF_PIN0), 8'h10);
    $display("test debounce done");
    wr(ba(gcm_pkg::OFF_MASK3), 8'h00);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ba(gcm_pkg::OFF_MASK3), 8'hFF);
    rd(ba(gcm_pkg::OFF_PIN0), 8'h22);
    $display("test second reset done");
    giveVerdict();
  end
endmodule : tb
